// ### verilog/fps_pkg.sv
package fps_pkg;
   // Register indices; byte address is four times the index
   localparam int IDX_CFG = 3;
   localparam int IDX_PROT = 4;
   localparam int IDX_STAT = 5;
   localparam logic [7:0] ADDR_CFG = 8'(IDX_CFG * 4);
   localparam logic [7:0] ADDR_PROT = 8'(IDX_PROT * 4);
   localparam logic [7:0] ADDR_STAT = 8'(IDX_STAT * 4);

   // Status fields
   localparam int ST_BUF_EMPTY = 7;
   localparam int ST_COMPLETE = 6;
   localparam int ST_VIOL = 5;
   localparam int ST_ACC_ERR = 4;
   localparam int ST_BLANK = 2;
   localparam int ST_FAIL = 1;
   localparam int ST_DONE = 0;

   // Protection fields
   localparam int PR_POLARITY = 7;
   localparam int PR_SPARE = 6;
   localparam int PR_HIGH_DIS = 5;
   localparam int PR_HIGH_SIZE = 3;
   localparam int PR_LOW_DIS = 2;
   localparam int PR_LOW_SIZE = 0;

   // Config fields
   localparam int CF_BUF_IRQ_EN = 7;
   localparam int CF_DONE_IRQ_EN = 6;

   localparam logic [7:0] PROT_RST = 8'hFF;
   localparam logic [7:0] CFG_RST = 8'h00;

   // Range bounds
   localparam logic [15:0] HIGH_BASE_0 = 16'hF800;
   localparam logic [15:0] HIGH_BASE_1 = 16'hF000;
   localparam logic [15:0] HIGH_BASE_2 = 16'hE000;
   localparam logic [15:0] HIGH_BASE_3 = 16'hC000;
   localparam logic [15:0] LOW_BASE = 16'h4000;
   localparam logic [15:0] LOW_END_0 = 16'h41FF;
   localparam logic [15:0] LOW_END_1 = 16'h43FF;
   localparam logic [15:0] LOW_END_2 = 16'h47FF;
   localparam logic [15:0] LOW_END_3 = 16'h4FFF;

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_ADDR = 2'b01,
      SEQ_CMD = 2'b10
   } fps_seq_e;
endpackage

// ### verilog/fps_flash_protect.sv
// Function
// - Polarity set: a cleared disable bit protects its range; both set protect nothing.
// - Polarity clear with both disable bits set protects the whole array.
// - Polarity clear: ranges with disable bit 0 stay open, rest is protected.
// - High size code selects F800, F000, E000 or C000 up to FFFF.
// - Low size code selects 4000 up to 41FF, 43FF, 47FF or 4FFF.
// - Protection loaded from array after reset, still writable by software.
// - Disallowed scenario write is dropped; protection register keeps its value.
// - Only listed scenario transitions are accepted, protection only added.
// - Reading protection register returns the scenario currently in force.
// - Normal modes: buffer, violation, error writable; complete, blank read-only; rest zero.
// - Special modes: fail readable and writable, done readable only.
// - Buffer-empty flag bit 7; write 1 clears it only when it launches a command, write 0 leaves it.
// - Writing 0 to buffer-empty mid-sequence aborts and sets access error.
// - Interrupt requested for buffer-empty or complete flag with its enable.
// - Complete flag bit 6 clears with buffer-empty, sets when all commands finish.
// - Violation bit 5 sets on protected program/erase, write-1 clear, blocks launch.
// - Access error bit 4 sets on sequence, command or stop fault, blocks launch.
// - Blank bit 2 set by erase-verify pass, cleared at valid launch.
// - Special modes: fail bit 1 sets on verify failure, write-1 clear, blocks launch.
// - Special modes: done bit 0 reads 0 while an operation is active.
// - Size fields take writes only while their disable bit is set.
module fps_flash_protect (
   input wire logic clock, // Bus clock
   input wire logic rstn, // Async reset, active low
   input wire logic [7:0] s_awaddr, // Write address
   input wire logic s_awvalid, // Write address valid
   output logic s_awready, // Write address ready
   input wire logic [31:0] s_wdata, // Write data
   input wire logic [3:0] s_wstrb, // Write strobes
   input wire logic s_wvalid, // Write data valid
   output logic s_wready, // Write data ready
   output logic [1:0] s_bresp, // Write response
   output logic s_bvalid, // Write response valid
   input wire logic s_bready, // Write response ready
   input wire logic [7:0] s_araddr, // Read address
   input wire logic s_arvalid, // Read address valid
   output logic s_arready, // Read address ready
   output logic [31:0] s_rdata, // Read data
   output logic [1:0] s_rresp, // Read response
   output logic s_rvalid, // Read data valid
   input wire logic s_rready, // Read data ready
   input wire logic special_mode, // Special (test) mode
   input wire logic nv_load, // Pulse: protection word fetched
   input wire logic [7:0] nv_prot, // Protection word from array
   input wire logic arr_wr, // Pulse: aligned word write to array
   input wire logic [15:0] arr_addr, // Address of that write
   input wire logic cmd_wr, // Pulse: command register written
   input wire logic cmd_legal, // Command code is valid
   input wire logic cmd_pe, // Command programs or erases
   input wire logic eng_take, // Pulse: engine took buffered command
   input wire logic eng_busy, // Engine operation active
   input wire logic verify_blank, // Pulse: erase-verify found erased
   input wire logic verify_fail, // Pulse: erase-verify found not erased
   input wire logic stop_req, // Pulse: processor stop instruction
   output logic cmd_launch, // Pulse: command launched
   output logic [15:0] launch_addr, // Address of launched command
   output logic irq_buffer_empty, // Interrupt request, buffer empty
   output logic irq_complete // Interrupt request, complete
);

   ////////////////////////////////////////////////////////////////
   function automatic logic [2:0] scen(input logic [7:0] p);
      scen = {p[fps_pkg::PR_POLARITY], p[fps_pkg::PR_HIGH_DIS], p[fps_pkg::PR_LOW_DIS]};
   endfunction

   // Bit n of the result: move to scenario n is allowed
   function automatic logic [7:0] allowed(input logic [2:0] from);
      case (from)
         3'd0: allowed = 8'b0000_1111;
         3'd1: allowed = 8'b0000_1010;
         3'd2: allowed = 8'b0000_1100;
         3'd3: allowed = 8'b0000_1000;
         3'd4: allowed = 8'b0001_1000;
         3'd5: allowed = 8'b0011_1100;
         3'd6: allowed = 8'b0101_1010;
         default: allowed = 8'b1111_1111;
      endcase
   endfunction

   // A bit-select straight on a call result is refused by strict front ends
   function automatic logic legal_move(input logic [7:0] from_p, input logic [7:0] to_p);
      logic [7:0] v;
      v = allowed(scen(from_p));
      legal_move = v[scen(to_p)];
   endfunction

   function automatic logic hit(input logic [15:0] a, input logic [7:0] p);
      logic [15:0] hb;
      logic [15:0] le;
      logic in_h;
      logic in_l;
      logic open_h;
      logic open_l;
      case (p[fps_pkg::PR_HIGH_SIZE +: 2])
         2'd0: hb = fps_pkg::HIGH_BASE_0;
         2'd1: hb = fps_pkg::HIGH_BASE_1;
         2'd2: hb = fps_pkg::HIGH_BASE_2;
         default: hb = fps_pkg::HIGH_BASE_3;
      endcase
      case (p[fps_pkg::PR_LOW_SIZE +: 2])
         2'd0: le = fps_pkg::LOW_END_0;
         2'd1: le = fps_pkg::LOW_END_1;
         2'd2: le = fps_pkg::LOW_END_2;
         default: le = fps_pkg::LOW_END_3;
      endcase
      in_h = (a >= hb);
      in_l = (a >= fps_pkg::LOW_BASE) && (a <= le);
      open_h = !p[fps_pkg::PR_HIGH_DIS] && in_h;
      open_l = !p[fps_pkg::PR_LOW_DIS] && in_l;
      if (p[fps_pkg::PR_POLARITY]) begin
         hit = open_h || open_l;
      end else begin
         hit = !(open_h || open_l);
      end
   endfunction

   ////////////////////////////////////////////////////////////////
   // Bus slave
   logic aw_full_reg;
   logic w_full_reg;
   logic [7:0] aw_addr_reg;
   logic [7:0] w_data_reg;
   logic w_strb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic wr_fire;
   logic wr_cfg;
   logic wr_prot;
   logic wr_stat;
   logic [7:0] wd;
   logic [7:0] rd_mux;
   logic rd_ok;

   assign s_awready = !aw_full_reg;
   assign s_wready = !w_full_reg;
   assign s_bvalid = bvalid_reg;
   assign s_bresp = bresp_reg;
   assign s_arready = !rvalid_reg;
   assign s_rvalid = rvalid_reg;
   assign s_rdata = rdata_reg;
   assign s_rresp = rresp_reg;

   assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
   assign wd = w_data_reg;
   assign wr_cfg = wr_fire && w_strb_reg && (aw_addr_reg == fps_pkg::ADDR_CFG);
   assign wr_prot = wr_fire && w_strb_reg && (aw_addr_reg == fps_pkg::ADDR_PROT);
   assign wr_stat = wr_fire && w_strb_reg && (aw_addr_reg == fps_pkg::ADDR_STAT);

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         aw_full_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
      end else if (s_awvalid && !aw_full_reg) begin
         aw_full_reg <= 1'b1;
         aw_addr_reg <= s_awaddr;
      end else if (wr_fire) begin
         aw_full_reg <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         w_full_reg <= 1'b0;
         w_data_reg <= 8'h00;
         w_strb_reg <= 1'b0;
      end else if (s_wvalid && !w_full_reg) begin
         w_full_reg <= 1'b1;
         w_data_reg <= s_wdata[7:0];
         w_strb_reg <= s_wstrb[0];
      end else if (wr_fire) begin
         w_full_reg <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= fps_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_reg <= 1'b1;
         case (aw_addr_reg)
            fps_pkg::ADDR_CFG, fps_pkg::ADDR_PROT, fps_pkg::ADDR_STAT: bresp_reg <= fps_pkg::RESP_OKAY;
            default: bresp_reg <= fps_pkg::RESP_SLVERR;
         endcase
      end else if (s_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Protection register
   logic [7:0] prot_reg;
   logic [7:0] prot_cand;
   logic move_ok;

   assign move_ok = legal_move(prot_reg, prot_cand);

   always_comb begin
      prot_cand = wd;
      prot_cand[fps_pkg::PR_SPARE] = prot_reg[fps_pkg::PR_SPARE];
      if (!prot_reg[fps_pkg::PR_HIGH_DIS]) begin
         prot_cand[fps_pkg::PR_HIGH_SIZE +: 2] = prot_reg[fps_pkg::PR_HIGH_SIZE +: 2];
      end
      if (!prot_reg[fps_pkg::PR_LOW_DIS]) begin
         prot_cand[fps_pkg::PR_LOW_SIZE +: 2] = prot_reg[fps_pkg::PR_LOW_SIZE +: 2];
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         prot_reg <= fps_pkg::PROT_RST;
      end else if (nv_load) begin
         prot_reg <= nv_prot;
      end else if (wr_prot && move_ok) begin
         prot_reg <= prot_cand;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Config register
   logic [7:0] cfg_reg;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cfg_reg <= fps_pkg::CFG_RST;
      end else if (wr_cfg) begin
         cfg_reg <= wd & 8'hC0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Command write sequence
   fps_pkg::fps_seq_e seq_reg;
   logic [15:0] seq_addr_reg;
   logic seq_pe_reg;
   logic buf_empty_reg;
   logic complete_reg;
   logic viol_reg;
   logic acc_err_reg;
   logic blank_reg;
   logic fail_reg;
   logic blocked;
   logic attempt;
   logic viol_set;
   logic go;
   logic abort0;
   logic seq_err;
   logic acc_set;

   assign blocked = viol_reg || acc_err_reg || fail_reg;
   assign attempt = wr_stat && wd[fps_pkg::ST_BUF_EMPTY] && (seq_reg == fps_pkg::SEQ_CMD);
   assign viol_set = attempt && !blocked && seq_pe_reg && hit(seq_addr_reg, prot_reg);
   assign go = attempt && !blocked && !viol_set;
   assign abort0 = wr_stat && !wd[fps_pkg::ST_BUF_EMPTY] && (seq_reg != fps_pkg::SEQ_IDLE);
   assign seq_err = (arr_wr && (seq_reg != fps_pkg::SEQ_IDLE))
      || (cmd_wr && (seq_reg != fps_pkg::SEQ_ADDR))
      || (cmd_wr && !cmd_legal);
   assign acc_set = abort0 || seq_err || (stop_req && !complete_reg);

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         seq_reg <= fps_pkg::SEQ_IDLE;
      end else begin
         case (seq_reg)
            fps_pkg::SEQ_IDLE: begin
               if (arr_wr) begin
                  seq_reg <= fps_pkg::SEQ_ADDR;
               end
            end
            fps_pkg::SEQ_ADDR: begin
               if (abort0 || arr_wr || (cmd_wr && !cmd_legal)) begin
                  seq_reg <= fps_pkg::SEQ_IDLE;
               end else if (cmd_wr) begin
                  seq_reg <= fps_pkg::SEQ_CMD;
               end
            end
            fps_pkg::SEQ_CMD: begin
               if (attempt || abort0 || arr_wr || cmd_wr) begin
                  seq_reg <= fps_pkg::SEQ_IDLE;
               end
            end
            default: seq_reg <= fps_pkg::SEQ_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         seq_addr_reg <= 16'h0000;
         seq_pe_reg <= 1'b0;
      end else begin
         if (arr_wr && (seq_reg == fps_pkg::SEQ_IDLE)) begin
            seq_addr_reg <= arr_addr;
         end
         if (cmd_wr && (seq_reg == fps_pkg::SEQ_ADDR)) begin
            seq_pe_reg <= cmd_pe;
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cmd_launch <= 1'b0;
         launch_addr <= 16'h0000;
      end else begin
         cmd_launch <= go;
         if (go) begin
            launch_addr <= seq_addr_reg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Status flags; a set in the clearing cycle wins
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         buf_empty_reg <= 1'b1;
      end else begin
         buf_empty_reg <= eng_take || (buf_empty_reg && !go);
      end
   end

   // Complete only once buffer drained and engine idle
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         complete_reg <= 1'b1;
      end else begin
         complete_reg <= buf_empty_reg && !go && !eng_busy;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         viol_reg <= 1'b0;
      end else begin
         viol_reg <= viol_set || (viol_reg && !(wr_stat && wd[fps_pkg::ST_VIOL]));
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         acc_err_reg <= 1'b0;
      end else begin
         acc_err_reg <= acc_set || (acc_err_reg && !(wr_stat && wd[fps_pkg::ST_ACC_ERR]));
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         blank_reg <= 1'b0;
      end else begin
         blank_reg <= verify_blank || (blank_reg && !go);
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         fail_reg <= 1'b0;
      end else begin
         fail_reg <= (special_mode && verify_fail)
            || (fail_reg && !(special_mode && wr_stat && wd[fps_pkg::ST_FAIL]));
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         irq_buffer_empty <= 1'b0;
         irq_complete <= 1'b0;
      end else begin
         irq_buffer_empty <= buf_empty_reg && cfg_reg[fps_pkg::CF_BUF_IRQ_EN];
         irq_complete <= complete_reg && cfg_reg[fps_pkg::CF_DONE_IRQ_EN];
      end
   end

   ////////////////////////////////////////////////////////////////
   // Read path
   always_comb begin
      rd_mux = 8'h00;
      rd_ok = 1'b1;
      case (s_araddr)
         fps_pkg::ADDR_CFG: rd_mux = cfg_reg;
         fps_pkg::ADDR_PROT: rd_mux = prot_reg;
         fps_pkg::ADDR_STAT: begin
            rd_mux[fps_pkg::ST_BUF_EMPTY] = buf_empty_reg;
            rd_mux[fps_pkg::ST_COMPLETE] = complete_reg;
            rd_mux[fps_pkg::ST_VIOL] = viol_reg;
            rd_mux[fps_pkg::ST_ACC_ERR] = acc_err_reg;
            rd_mux[fps_pkg::ST_BLANK] = blank_reg;
            rd_mux[fps_pkg::ST_FAIL] = special_mode && fail_reg;
            rd_mux[fps_pkg::ST_DONE] = special_mode && !eng_busy;
         end
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= fps_pkg::RESP_OKAY;
      end else if (s_arvalid && !rvalid_reg) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= {24'h00_0000, rd_mux};
         rresp_reg <= rd_ok ? fps_pkg::RESP_OKAY : fps_pkg::RESP_SLVERR;
      end else if (s_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   sequence s_launch_try;
      attempt && blocked;
   endsequence

   sequence s_no_launch;
      !cmd_launch ##1 !cmd_launch;
   endsequence

   a_launch_blocked: assert property (s_launch_try |=> s_no_launch) else $error("launch while blocked");
   a_launch_clean: assert property (cmd_launch |-> !$past(blocked)) else $error("launch with error flag set");
   a_viol_set: assert property (viol_set |=> viol_reg && !cmd_launch) else $error("violation not flagged");
   a_bad_scen: assert property (wr_prot && !nv_load && !move_ok |=> $stable(prot_reg))
      else $error("bad scenario accepted");
   a_scen_move: assert property (!$past(nv_load) && $changed(prot_reg)
      |-> legal_move($past(prot_reg), prot_reg)) else $error("illegal scenario move");
   a_abort_err: assert property (abort0 |=> acc_err_reg && seq_reg == fps_pkg::SEQ_IDLE)
      else $error("abort not flagged");
   a_done_clear: assert property (!buf_empty_reg |=> !complete_reg) else $error("complete with full buffer");
   a_stop_err: assert property (stop_req && !complete_reg |=> acc_err_reg) else $error("stop not flagged");
   a_blank_drop: assert property (go && !verify_blank |=> !blank_reg && cmd_launch) else $error("blank kept");
   a_irq_gate: assert property (irq_complete
      |-> $past(complete_reg) && $past(cfg_reg[fps_pkg::CF_DONE_IRQ_EN])) else $error("spurious complete irq");
   a_fail_norm: assert property (!special_mode && !$past(special_mode) && !fail_reg |=> !fail_reg)
      else $error("fail set in normal mode");
   // Both beat holders must have drained when the response goes out
   a_wr_resp: assert property (wr_fire |=> s_bvalid && s_awready && s_wready)
      else $error("write response missing");
endmodule

// ### tb/fps_engine_model.sv
module fps_engine_model (
   input wire logic clock, // Bus clock
   input wire logic rstn, // Async reset, active low
   input wire logic cmd_launch, // Launch pulse from block
   input wire logic cmd_pe, // Command type, held by bench
   input wire logic slow, // Long operation when high
   input wire logic fail_res, // Verify finds array not erased
   output logic eng_take, // Buffered command taken
   output logic eng_busy, // Operation active
   output logic verify_blank, // Verify passed
   output logic verify_fail // Verify failed
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt_reg;
   logic ver_reg;
   // Takes the command at once, so a new one can queue while busy
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt_reg <= 0;
         ver_reg <= 0;
         eng_take <= 0;
         eng_busy <= 0;
         verify_blank <= 0;
         verify_fail <= 0;
      end else begin
         eng_take <= 0;
         verify_blank <= 0;
         verify_fail <= 0;
         if (cmd_launch) begin
            eng_take <= 1;
            eng_busy <= 1;
            cnt_reg <= slow ? 12 : 3;
            ver_reg <= !cmd_pe;
         end else if (cnt_reg > 1) begin
            cnt_reg <= cnt_reg - 1;
         end else if (eng_busy) begin
            eng_busy <= 0;
            verify_blank <= ver_reg && !fail_res;
            verify_fail <= ver_reg && fail_res;
         end
      end
   end
endmodule

// ### tb/fps_flash_protect_tb.sv
module fps_flash_protect_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, rstn;
   logic [7:0] s_awaddr = 0, s_araddr = 0, nv_prot = 0, p0, w, cand;
   logic [31:0] s_wdata = 0, s_rdata, rdat, r;
   logic [3:0] s_wstrb = 4'hF;
   logic s_awvalid = 0, s_wvalid = 0, s_bready = 1, s_arvalid = 0, s_rready = 1;
   logic special_mode = 0, nv_load = 0, arr_wr = 0, cmd_wr = 0, cmd_legal = 1, cmd_pe = 1, stop_req = 0;
   logic slow = 0, fail_res = 0;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, cmd_launch, irq_buffer_empty, irq_complete;
   logic eng_take, eng_busy, verify_blank, verify_fail;
   logic [1:0] s_bresp, s_rresp, bres;
   logic [15:0] arr_addr = 0, launch_addr, la, a16;
   int bad_count = 0, total_checks = 0, nl = 0, n0;
   // Allowed targets, one byte per source scenario
   localparam logic [63:0] ALW = 64'hFF5A_3C18_080C_0A0F;

   fps_flash_protect i_fps_flash_protect (.clock, .rstn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
      .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
      .s_rdata, .s_rresp, .s_rvalid, .s_rready, .special_mode, .nv_load, .nv_prot, .arr_wr, .arr_addr,
      .cmd_wr, .cmd_legal, .cmd_pe, .eng_take, .eng_busy, .verify_blank, .verify_fail, .stop_req,
      .cmd_launch, .launch_addr, .irq_buffer_empty, .irq_complete);
   fps_engine_model i_fps_engine_model (.clock, .rstn, .cmd_launch, .cmd_pe, .slow, .fail_res,
      .eng_take, .eng_busy, .verify_blank, .verify_fail);

   initial begin
      clock = 0;
      forever #2 clock = ~clock;
   end

   always @(negedge clock) begin
      if (cmd_launch === 1'b1) begin
         nl++;
         la = launch_addr;
      end
   end

   initial begin
      repeat (60000) @(posedge clock);
      bad_count++;
      finish_test();
   end

   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic bit hit(input logic [7:0] p, input logic [15:0] a);
      logic [15:0] hb, le;
      bit inr;
      hb = 16'hFFFF << (11 + p[4:3]);
      le = 16'h4000 | ((16'h0200 << p[1:0]) - 16'h0001);
      inr = (!p[5] && a >= hb) || (!p[2] && a >= 16'h4000 && a <= le);
      return p[7] ? inr : !inr;
   endfunction

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic finish_test();
      if (bad_count == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Handshakes are judged at the negedge before the edge that completes them
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic pa, pw, ta, tw;
      @(posedge clock);
      s_awaddr <= a;
      s_wdata <= {24'h0, d};
      s_awvalid <= 1;
      s_wvalid <= 1;
      pa = 1;
      pw = 1;
      while (pa || pw) begin
         @(negedge clock);
         ta = pa && s_awready;
         tw = pw && s_wready;
         @(posedge clock);
         if (ta) s_awvalid <= 0;
         if (tw) s_wvalid <= 0;
         pa = pa && !ta;
         pw = pw && !tw;
      end
      do @(negedge clock); while (s_bvalid !== 1'b1);
      bres = s_bresp;
      @(posedge clock);
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      s_araddr <= a;
      s_arvalid <= 1;
      do @(negedge clock); while (s_arready !== 1'b1);
      @(posedge clock);
      s_arvalid <= 0;
      do @(negedge clock); while (s_rvalid !== 1'b1);
      rdat = s_rdata;
      bres = s_rresp;
      @(posedge clock);
   endtask

   task automatic ld(input logic [7:0] p);
      @(posedge clock);
      nv_prot <= p;
      nv_load <= 1;
      @(posedge clock);
      nv_load <= 0;
   endtask

   task automatic seq(input logic [15:0] a, input logic lg, input logic pe, input logic [7:0] sv);
      @(posedge clock);
      arr_wr <= 1;
      arr_addr <= a;
      @(posedge clock);
      arr_wr <= 0;
      cmd_wr <= 1;
      cmd_legal <= lg;
      cmd_pe <= pe;
      @(posedge clock);
      cmd_wr <= 0;
      wr(fps_pkg::ADDR_STAT, sv);
      repeat (4) @(posedge clock);
   endtask

   task automatic wait_done();
      int n;
      n = 0;
      do begin
         rd(fps_pkg::ADDR_STAT);
         n++;
      end while (rdat[6] !== 1'b1 && n < 40);
      rd(fps_pkg::ADDR_STAT);
   endtask

   ////////////////////////////////////////////////////////////////
   initial begin
      rstn = 0;
      r = 32'h3e81_71b5;
      repeat (20) @(posedge clock);
      rstn <= 1;
      rd(fps_pkg::ADDR_PROT);
      chk(rdat, 32'h0000_00FF);
      rd(fps_pkg::ADDR_STAT);
      chk(rdat, 32'h0000_00C0);
      rd(8'h40);
      chk(32'(bres), 32'h0000_0002);
      wr(8'h40, 8'hFF);
      chk(32'(bres), 32'h0000_0002);
      for (int f = 0; f < 8; f++) begin
         for (int t = 0; t < 8; t++) begin
            r = lfsr(r);
            p0 = {f[2], r[6], f[1], r[4:3], f[0], r[1:0]};
            w = {t[2], r[14], t[1], r[12:11], t[0], r[9:8]};
            cand = {w[7], p0[6], w[5], p0[5] ? w[4:3] : p0[4:3], w[2], p0[2] ? w[1:0] : p0[1:0]};
            ld(p0);
            wr(fps_pkg::ADDR_PROT, w);
            chk(32'(bres), 32'h0000_0000);
            rd(fps_pkg::ADDR_PROT);
            chk(rdat, ALW[f * 8 + t] ? 32'(cand) : 32'(p0));
         end
      end
      // Range edges under random configurations
      for (int k = 0; k < 12; k++) begin
         r = lfsr(r);
         p0 = r[7:0];
         ld(p0);
         if (k % 4 < 2) a16 = (16'hFFFF << (11 + p0[4:3])) - 16'(k % 2);
         else a16 = (16'h4000 | ((16'h0200 << p0[1:0]) - 16'h0001)) + 16'(k % 2);
         n0 = nl;
         seq(a16, 1, 1, 8'h80);
         rd(fps_pkg::ADDR_STAT);
         chk(32'(rdat[5]), 32'(hit(p0, a16)));
         chk(32'(nl - n0), 32'(!hit(p0, a16)));
         if (hit(p0, a16)) wr(fps_pkg::ADDR_STAT, 8'h20);
         else wait_done();
         if (!hit(p0, a16)) chk(32'(la), 32'(a16));
      end
      ld(8'hFF);
      wr(fps_pkg::ADDR_STAT, 8'h00);
      rd(fps_pkg::ADDR_STAT);
      chk(rdat, 32'h0000_00C0);
      seq(16'h8000, 1, 1, 8'h00);
      rd(fps_pkg::ADDR_STAT);
      chk(rdat, 32'h0000_00D0);
      n0 = nl;
      seq(16'h8000, 1, 1, 8'h80);
      chk(32'(nl - n0), 32'h0000_0000);
      wr(fps_pkg::ADDR_STAT, 8'h10);
      seq(16'h8000, 0, 1, 8'h80);
      rd(fps_pkg::ADDR_STAT);
      chk(rdat, 32'h0000_00D0);
      chk(32'(nl - n0), 32'h0000_0000);
      wr(fps_pkg::ADDR_STAT, 8'h10);
      slow <= 1;
      seq(16'h8000, 1, 1, 8'h80);
      stop_req <= 1;
      @(posedge clock);
      stop_req <= 0;
      rd(fps_pkg::ADDR_STAT);
      chk(32'(rdat[4]), 32'h0000_0001);
      wait_done();
      wr(fps_pkg::ADDR_STAT, 8'h10);
      seq(16'h8000, 1, 0, 8'h80);
      wait_done();
      chk(rdat, 32'h0000_00C4);
      wr(fps_pkg::ADDR_STAT, 8'h44);
      rd(fps_pkg::ADDR_STAT);
      chk(rdat, 32'h0000_00C4);
      seq(16'h8000, 1, 1, 8'h80);
      wait_done();
      chk(rdat, 32'h0000_00C0);
      special_mode <= 1;
      fail_res <= 1;
      seq(16'h8000, 1, 0, 8'h80);
      rd(fps_pkg::ADDR_STAT);
      chk(32'({rdat[6], rdat[0]}), 32'h0000_0000);
      wait_done();
      chk(rdat, 32'h0000_00C3);
      wr(fps_pkg::ADDR_STAT, 8'h01);
      rd(fps_pkg::ADDR_STAT);
      chk(rdat, 32'h0000_00C3);
      n0 = nl;
      seq(16'h8000, 1, 1, 8'h80);
      chk(32'(nl - n0), 32'h0000_0000);
      wr(fps_pkg::ADDR_STAT, 8'h02);
      rd(fps_pkg::ADDR_STAT);
      chk(rdat, 32'h0000_00C1);
      special_mode <= 0;
      wr(fps_pkg::ADDR_CFG, 8'hC0);
      @(negedge clock);
      chk(32'({irq_buffer_empty, irq_complete}), 32'h0000_0003);
      wr(fps_pkg::ADDR_CFG, 8'h40);
      seq(16'h8000, 1, 1, 8'h80);
      @(negedge clock);
      chk(32'({irq_buffer_empty, irq_complete}), 32'h0000_0000);
      wait_done();
      @(negedge clock);
      chk(32'({irq_buffer_empty, irq_complete}), 32'h0000_0001);
      finish_test();
   end
endmodule
